/* File: bench/etp_timers_monitor.sv */
// checker for the timer block: bus handshake, readback and status outputs
// sees only the top module ports, bound to every etp_timers instance
`timescale 1ns/1ps
module etp_timers_monitor (
  // clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // status outputs
  input wire        osc_pins_claimed_ff,
  input wire        timer_irq_ff
);
  reg  [7:0] cmp_ff;
  reg        glob_ff;
  reg        async_ff;
  wire       wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire       rd_hit = wb_ack_o && !wb_we_i;
  // shadows follow writes at the ack edge, where the block applies them
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cmp_ff   <= 8'h00;
      glob_ff  <= 1'b0;
      async_ff <= 1'b0;
    end else if (wr_hit) begin
      if (wb_adr_i == 8'hC4) cmp_ff <= wb_dat_i[7:0];
      if (wb_adr_i == 8'hE4) glob_ff <= wb_dat_i[7];
      if (wb_adr_i == 8'h88) async_ff <= wb_dat_i[3];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (rd_hit |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_async_rsvd_zero: assert property (
    rd_hit && wb_adr_i == 8'h88 |-> wb_dat_o[7:4] == 4'h0)
    else $error("async status reserved bits not zero");
  a_cmp_read_last: assert property (
    rd_hit && wb_adr_i == 8'hC4 |-> wb_dat_o[7:0] == cmp_ff)
    else $error("compare read differs from last write");
  a_irq_global_gate: assert property (!$past(glob_ff) |-> !timer_irq_ff)
    else $error("irq raised with global enable off");
  a_osc_claim_follow: assert property (
    osc_pins_claimed_ff == $past(async_ff))
    else $error("oscillator claim does not follow async bit");
  a_unmapped_zero: assert property (rd_hit && wb_adr_i == 8'h00 |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
endmodule // etp_timers_monitor

bind etp_timers etp_timers_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .osc_pins_claimed_ff(osc_pins_claimed_ff), .timer_irq_ff(timer_irq_ff));

/* File: bench/tb.sv */
// self-checking bench for the two-timer block over wishbone
// assumes one 100 MHz clock, clock enable held high throughout
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin \
  n_mismatch = n_mismatch + 1; $display("[ERR] %0t got %h exp %h", $time, \
  (a), (b)); end end
module tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         wb_we_i = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [31:0] wb_dat_i = 32'h0;
  reg         ext_in = 1'b0;
  reg         osc_in = 1'b0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        pin0;
  wire        pin2;
  wire        claimed;
  wire        irq;
  integer     n_mismatch = 0;
  integer     comparisons = 0;
  integer     i;
  integer     n;
  reg  [7:0]  q;
  integer     d0 [0:4] = '{1, 8, 64, 256, 1024};
  integer     d2 [0:6] = '{1, 8, 32, 64, 128, 256, 1024};
  // ctrl, compare, expected high cycles out of 1024, tolerance
  integer     pw [0:8][0:3] = '{'{8'h61, 8'h40, 256, 8}, '{8'h71, 8'h40, 768, 10},
    '{8'h69, 8'h40, 260, 10}, '{8'h79, 8'h40, 764, 10}, '{8'h61, 8'hFF, 1024, 0},
    '{8'h61, 8'h00, 0, 0}, '{8'h71, 8'h00, 1024, 0}, '{8'h69, 8'hFF, 0, 0},
    '{8'h79, 8'hFF, 1024, 0}};

  etp_timers dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_count_input(ext_in), .async_osc_input(osc_in),
    .timer0_compare_pin(pin0), .timer2_compare_pin(pin2),
    .osc_pins_claimed_ff(claimed), .timer_irq_ff(irq));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task finish_test;
    begin
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // one classic cycle; the request stays put until ack is sampled
  task xfer(input we, input [7:0] a, input [7:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) @(posedge ref_clk);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      xfer(1'b0, a, 8'h00);
      `CHK(q, e)
    end
  endtask

  // run a timer for 20 prescaled ticks, then stop it and read the count
  task run_div(input [7:0] ca, input [7:0] na, input [7:0] cs, input integer dv);
    begin
      wr(ca, 8'h00);
      wr(na, 8'h00);
      wr(ca, cs);
      repeat (dv * 20) @(posedge ref_clk);
      wr(ca, 8'h00);
      xfer(1'b0, na, 8'h00);
    end
  endtask

  initial begin
    // tests need about 75k cycles; this leaves margin without breaking limit
    repeat (90000) @(posedge ref_clk);
    n_mismatch = n_mismatch + 1;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'hC8, 8'h00);
    rd(8'hCC, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    wr(8'hC8, 8'h10);
    rd(8'hC8, 8'h10);
    for (i = 0; i < 5; i = i + 1) begin
      run_div(8'hCC, 8'hC8, i + 1, d0[i]);
      `CHK(q >= 19 && q <= ((i == 0) ? 26 : 22), 1'b1)
    end
    for (i = 0; i < 7; i = i + 1) begin
      run_div(8'h9C, 8'h90, i + 1, d2[i]);
      `CHK(q >= 19 && q <= ((i == 0) ? 26 : 22), 1'b1)
    end
    for (i = 6; i < 8; i = i + 1) begin
      wr(8'hC8, 8'h00);
      wr(8'hCC, i);
      repeat (10) begin
        ext_in <= ~ext_in;
        repeat (4) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
      wr(8'hCC, 8'h00);
      rd(8'hC8, 8'h05);
    end
    wr(8'hE0, 8'hFF);
    wr(8'hC4, 8'h05);
    wr(8'hC8, 8'h00);
    wr(8'hE4, 8'h82);
    wr(8'hCC, 8'h01);
    repeat (20) @(posedge ref_clk);
    wr(8'hCC, 8'h00);
    rd(8'hE0, 8'h02);
    `CHK(irq, 1'b1)
    wr(8'hE4, 8'h02);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(8'hE0, 8'hFF);
    wr(8'hCC, 8'h01);
    wr(8'hC8, 8'h05);
    wr(8'hCC, 8'h00);
    rd(8'hE0, 8'h00);
    xfer(1'b0, 8'hC8, 8'h00);
    `CHK(q > 8'h05 && q < 8'h0A, 1'b1)
    for (i = 0; i < 9; i = i + 1) begin
      wr(8'hCC, 8'h00);
      wr(8'hC4, pw[i][1]);
      wr(8'hCC, pw[i][0]);
      repeat (600) @(posedge ref_clk);
      n = 0;
      repeat (1024) begin
        @(negedge ref_clk);
        n = n + pin0;
      end
      `CHK(n >= pw[i][2] - pw[i][3] && n <= pw[i][2] + pw[i][3], 1'b1)
    end
    wr(8'hC4, 8'h33);
    rd(8'hC4, 8'h33);
    xfer(1'b0, 8'hE0, 8'h00);
    `CHK(q[0], 1'b1)
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'h08);
    `CHK(claimed, 1'b1)
    wr(8'h9C, 8'h00);
    wr(8'h90, 8'h00);
    wr(8'h9C, 8'h01);
    repeat (8) begin
      osc_in <= ~osc_in;
      repeat (10) @(posedge ref_clk);
    end
    wr(8'h9C, 8'h00);
    rd(8'h90, 8'h04);
    wr(8'h88, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK(claimed, 1'b0)
    wr(8'h8C, 8'h02);
    wr(8'h90, 8'h00);
    wr(8'h9C, 8'h31);
    repeat (10) @(posedge ref_clk);
    `CHK(pin2, 1'b1)
    finish_test;
  end
endmodule // tb

/* File: rtl/etp_consts.vh */
// constants for the two 8-bit timer/counter block with pwm
// assumes a wishbone byte address, register index = byte address / 4
`ifndef ETP_CONSTS_VH
`define ETP_CONSTS_VH

// register indexes, byte address is four times the index
`define ETP_IDX_T0_COUNT    6'h32
`define ETP_IDX_T0_CTRL     6'h33
`define ETP_IDX_T0_CMP      6'h31
`define ETP_IDX_T2_CTRL     6'h27
`define ETP_IDX_T2_COUNT    6'h24
`define ETP_IDX_T2_CMP      6'h23
`define ETP_IDX_ASYNC_STAT  6'h22
`define ETP_IDX_FLAGS       6'h38
`define ETP_IDX_MASK        6'h39

// control register fields, async select bit and global interrupt enable bit
`define ETP_CTL_PWM         6
`define ETP_CTL_COM_HI      5
`define ETP_CTL_COM_LO      4
`define ETP_CTL_CTC         3
`define ETP_ASYNC_SEL_BIT   3
`define ETP_MASK_GLOBAL     7

// reset values
`define ETP_RST_BYTE        8'h00
`define ETP_RST_CTL         7'h00

// counter end points
`define ETP_CNT_TOP         8'hFF
`define ETP_CNT_BOT         8'h00

// prescaler masks, a tick falls where the masked bits are all ones
`define ETP_DIV1            10'h000
`define ETP_DIV8            10'h007
`define ETP_DIV32           10'h01F
`define ETP_DIV64           10'h03F
`define ETP_DIV128          10'h07F
`define ETP_DIV256          10'h0FF
`define ETP_DIV1024         10'h3FF

`endif

/* File: rtl/etp_timers.v */
// two 8-bit timer/counters with compare output and pwm, wishbone slave
// assumes one core clock, classic wishbone master, raw pins from outside
// Operation
// - t0 select: core clock or /8 /64 /256 /1024
// - t0 codes 110/111 count pin falling/rising
// - t2 select: /1 /8 /32 /64 /128 /256 /1024
// - select zero stops the counter
// - t0 divides core clock, t2 its source
// - pin edges count even when pin drives
// - counter writable, resumes next timer tick
// - counter write blocks next tick's match
// - compare flag sets cycle after equality
// - pwm without clear bit counts up/down
// - pwm with clear bit wraps at top
// - up/down pin: clear up, set down
// - overflow pwm: clear match, set overflow
// - pwm compare writes latch at top
// - compare read returns last written value
// - up/down 00 or FF gives constant pin
// - overflow pwm constant only for FF
// - up/down overflow when leaving zero
// - interrupt needs flag, enable and global
// - async bit moves t2 to oscillator pin
// - async status upper bits read zero
// - pwm enable bit selects pwm operation
// - t2 source defaults to core clock
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "etp_consts.vh"

module etp_timers (
  // clock, reset, enable
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  // wishbone slave
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [7:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg        wb_ack_o,
  // pins
  input  wire       external_count_input,
  input  wire       async_osc_input,
  output wire       timer0_compare_pin,
  output wire       timer2_compare_pin,
  output reg        osc_pins_claimed_ff,
  // interrupt request
  output reg        timer_irq_ff
);

  wire [5:0]  idx = wb_adr_i[7:2];
  wire        req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  wire        wr  = clk_en & req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [7:0]  wd  = wb_dat_i[7:0];

  reg         async_sel_ff;
  reg  [7:0]  mask_ff;
  reg  [9:0]  pre0_ff;
  reg  [9:0]  pre2_ff;
  reg         ext_s1_ff, ext_s2_ff, ext_s3_ff;
  reg         osc_s1_ff, osc_s2_ff, osc_s3_ff;

  wire [1:0]  wr_cnt;
  wire [1:0]  wr_cmp;
  wire [1:0]  wr_ctl;
  wire [1:0]  tick;
  wire [15:0] cnt_w;
  wire [15:0] cmp_w;
  wire [13:0] ctl_w;
  wire [3:0]  flag_w;
  wire [1:0]  pin_w;

  assign wr_cnt[0] = wr & (idx == `ETP_IDX_T0_COUNT);
  assign wr_cnt[1] = wr & (idx == `ETP_IDX_T2_COUNT);
  assign wr_cmp[0] = wr & (idx == `ETP_IDX_T0_CMP);
  assign wr_cmp[1] = wr & (idx == `ETP_IDX_T2_CMP);
  assign wr_ctl[0] = wr & (idx == `ETP_IDX_T0_CTRL);
  assign wr_ctl[1] = wr & (idx == `ETP_IDX_T2_CTRL);
  wire   wr_flags  = wr & (idx == `ETP_IDX_FLAGS);

  assign timer0_compare_pin = pin_w[0];
  assign timer2_compare_pin = pin_w[1];

  function sel_tick;
    input [9:0] pre;
    input [9:0] msk;
    begin
      sel_tick = ((pre & msk) == msk);
    end
  endfunction

  // two-flop synchronisers, third flop only feeds edge detection
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else if (clk_en) begin
      ext_s1_ff <= external_count_input;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      osc_s1_ff <= async_osc_input;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  // input pin is sampled unconditionally, so software driving it counts
  wire ext_rise = ext_s2_ff & ~ext_s3_ff;
  wire ext_fall = ~ext_s2_ff & ext_s3_ff;
  // t2 source: core clock unless async mode picks the oscillator edge
  wire timer2_prescaler_source = async_sel_ff ? (osc_s2_ff & ~osc_s3_ff) : 1'b1;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pre0_ff <= 10'h000;
      pre2_ff <= 10'h000;
    end else if (clk_en) begin
      pre0_ff <= pre0_ff + 10'h001;
      if (timer2_prescaler_source)
        pre2_ff <= pre2_ff + 10'h001;
    end
  end

  reg t0_tick;
  reg t2_tick;
  always @* begin
    case (ctl_w[2:0])
      3'h1:    t0_tick = 1'b1;
      3'h2:    t0_tick = sel_tick(pre0_ff, `ETP_DIV8);
      3'h3:    t0_tick = sel_tick(pre0_ff, `ETP_DIV64);
      3'h4:    t0_tick = sel_tick(pre0_ff, `ETP_DIV256);
      3'h5:    t0_tick = sel_tick(pre0_ff, `ETP_DIV1024);
      3'h6:    t0_tick = ext_fall;
      3'h7:    t0_tick = ext_rise;
      default: t0_tick = 1'b0;
    endcase
    case (ctl_w[9:7])
      3'h1:    t2_tick = timer2_prescaler_source;
      3'h2:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV8);
      3'h3:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV32);
      3'h4:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV64);
      3'h5:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV128);
      3'h6:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV256);
      3'h7:    t2_tick = timer2_prescaler_source & sel_tick(pre2_ff, `ETP_DIV1024);
      default: t2_tick = 1'b0;
    endcase
  end
  assign tick[0] = clk_en & t0_tick;
  assign tick[1] = clk_en & t2_tick;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_tmr
      reg  [7:0] cnt_ff;
      reg  [7:0] cmp_ff;
      reg  [7:0] cmp_buf_ff;
      reg        pend_ff;
      reg  [6:0] ctl_ff;
      reg        down_ff;
      reg        block_ff;
      reg        pin_ff;
      reg        ovf_ff;
      reg        cmf_ff;

      wire pwm    = ctl_ff[`ETP_CTL_PWM];
      wire ctc    = ctl_ff[`ETP_CTL_CTC];
      wire com_hi = ctl_ff[`ETP_CTL_COM_HI];
      wire com_lo = ctl_ff[`ETP_CTL_COM_LO];
      wire at_top = (cnt_ff == `ETP_CNT_TOP);
      wire at_bot = (cnt_ff == `ETP_CNT_BOT);
      // a counter write suppresses the match of the next timer tick
      wire match  = tick[i] & (cnt_ff == cmp_ff) & ~block_ff;
      wire updown = pwm & ~ctc;
      wire ovf_ev = tick[i] & (updown ? at_bot : at_top);
      wire clr_ov = wr_flags & wd[2*i];
      wire clr_cm = wr_flags & wd[2*i+1];

      reg  [7:0] nxt_cnt;
      reg        nxt_down;
      reg        nxt_pin;

      always @* begin
        nxt_cnt  = cnt_ff;
        nxt_down = down_ff;
        nxt_pin  = pin_ff;
        if (tick[i]) begin
          if (updown) begin
            if (!down_ff && at_top) begin
              nxt_down = 1'b1;
              nxt_cnt  = cnt_ff - 8'h01;
            end else if (down_ff && at_bot) begin
              nxt_down = 1'b0;
              nxt_cnt  = cnt_ff + 8'h01;
            end else if (down_ff) begin
              nxt_cnt  = cnt_ff - 8'h01;
            end else begin
              nxt_cnt  = cnt_ff + 8'h01;
            end
          end else if (!pwm && ctc && match) begin
            nxt_cnt  = `ETP_CNT_BOT;
          end else begin
            nxt_cnt  = cnt_ff + 8'h01;
            nxt_down = 1'b0;
          end
        end
        if (pwm && com_hi) begin
          if (updown && match) begin
            if (cmp_ff == `ETP_CNT_BOT)
              nxt_pin = com_lo;
            else if (cmp_ff == `ETP_CNT_TOP)
              nxt_pin = ~com_lo;
            else
              nxt_pin = down_ff ^ com_lo;
          end else if (!updown && match) begin
            // match at top beats overflow, so FF holds a constant level
            nxt_pin = com_lo;
          end else if (!updown && tick[i] && at_top) begin
            nxt_pin = ~com_lo;
          end
        end else if (!pwm && match) begin
          case ({com_hi, com_lo})
            2'h1:    nxt_pin = ~pin_ff;
            2'h2:    nxt_pin = 1'b0;
            2'h3:    nxt_pin = 1'b1;
            default: nxt_pin = pin_ff;
          endcase
        end
        if (wr_cnt[i])
          nxt_cnt = wd;
      end

      always @(posedge ref_clk) begin
        if (!rst_n) begin
          cnt_ff     <= `ETP_RST_BYTE;
          cmp_ff     <= `ETP_RST_BYTE;
          cmp_buf_ff <= `ETP_RST_BYTE;
          pend_ff    <= 1'b0;
          ctl_ff     <= `ETP_RST_CTL;
          down_ff    <= 1'b0;
          block_ff   <= 1'b0;
          pin_ff     <= 1'b0;
          ovf_ff     <= 1'b0;
          cmf_ff     <= 1'b0;
        end else if (clk_en) begin
          cnt_ff  <= nxt_cnt;
          down_ff <= nxt_down;
          pin_ff  <= nxt_pin;
          if (wr_cnt[i])
            block_ff <= 1'b1;
          else if (tick[i])
            block_ff <= 1'b0;
          if (wr_ctl[i])
            ctl_ff <= wd[6:0];
          if (wr_cmp[i]) begin
            cmp_buf_ff <= wd;
            if (pwm) begin
              pend_ff <= 1'b1;
            end else begin
              cmp_ff  <= wd;
              pend_ff <= 1'b0;
            end
          end else if (pwm && pend_ff && tick[i] && at_top) begin
            cmp_ff  <= cmp_buf_ff;
            pend_ff <= 1'b0;
          end
          // set wins over a clear in the same cycle
          if (ovf_ev)
            ovf_ff <= 1'b1;
          else if (clr_ov)
            ovf_ff <= 1'b0;
          if (match)
            cmf_ff <= 1'b1;
          else if (clr_cm)
            cmf_ff <= 1'b0;
        end
      end

      assign cnt_w[8*i+7:8*i]   = cnt_ff;
      assign cmp_w[8*i+7:8*i]   = cmp_buf_ff;
      assign ctl_w[7*i+6:7*i]   = ctl_ff;
      assign flag_w[2*i+1:2*i]  = {cmf_ff, ovf_ff};
      assign pin_w[i]           = pin_ff;
    end
  endgenerate

  // software must rewrite timer 2 after flipping this bit
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      async_sel_ff        <= 1'b0;
      osc_pins_claimed_ff <= 1'b0;
      mask_ff             <= `ETP_RST_BYTE;
      timer_irq_ff        <= 1'b0;
    end else if (clk_en) begin
      if (wr && idx == `ETP_IDX_ASYNC_STAT)
        async_sel_ff <= wd[`ETP_ASYNC_SEL_BIT];
      if (wr && idx == `ETP_IDX_MASK)
        mask_ff <= wd;
      osc_pins_claimed_ff <= async_sel_ff;
      timer_irq_ff <= mask_ff[`ETP_MASK_GLOBAL] &
                      (|(flag_w & mask_ff[3:0]));
    end
  end

  reg [7:0] rd;
  always @* begin
    if (idx == `ETP_IDX_T0_COUNT)
      rd = cnt_w[7:0];
    else if (idx == `ETP_IDX_T2_COUNT)
      rd = cnt_w[15:8];
    else if (idx == `ETP_IDX_T0_CMP)
      rd = cmp_w[7:0];
    else if (idx == `ETP_IDX_T2_CMP)
      rd = cmp_w[15:8];
    else if (idx == `ETP_IDX_T0_CTRL)
      rd = {1'b0, ctl_w[6:0]};
    else if (idx == `ETP_IDX_T2_CTRL)
      rd = {1'b0, ctl_w[13:7]};
    else if (idx == `ETP_IDX_ASYNC_STAT)
      rd = {4'h0, async_sel_ff, 3'h0};
    else if (idx == `ETP_IDX_FLAGS)
      rd = {4'h0, flag_w};
    else if (idx == `ETP_IDX_MASK)
      rd = mask_ff;
    else
      rd = 8'h00;
  end

  // one wait state: ack rises the cycle after the request, drops after
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o)
        wb_dat_o <= {24'h000000, rd};
    end
  end

endmodule // etp_timers
